// >>> dv/imbs_chk.sv
// port checker for the i2c master byte sequencer
`timescale 1ns/10ps
module imbs_chk (
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  input wire logic                 ce,
  input wire logic [4:0]           regAddr,
  input wire logic [31:0]          regWdata,
  input wire logic                 regWr,
  input wire logic                 regRd,
  input wire logic [31:0]          regRdata,
  input wire imbs_pkg::imbs_pins_t pinsIn,
  input wire imbs_pkg::imbs_pad_t  padOut,
  input wire logic                 irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [15:0] lowCnt; // samples of scl driven low
  logic        dirty;  // run touched by irq or write
  logic [11:0] sclL;   // shadow low period
  logic [11:0] hold;   // shadow sda hold
  logic        wSt;    // status write
  logic        wCt;    // control write
  assign wSt = regWr && regAddr == imbs_pkg::OFS_STAT;
  assign wCt = regWr && regAddr == imbs_pkg::OFS_CTRL;
  // low run length and shadow timing values
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= 16'h0000;
      dirty <= 1'b1;
      sclL <= 12'h03F;
      hold <= 12'h001;
    end else begin
      lowCnt <= padOut.sclOeN ? 16'h0000 : lowCnt + 16'h0001;
      dirty <= padOut.sclOeN ? 1'b0 : (dirty | irq | regWr);
      if (regWr && regAddr == imbs_pkg::OFS_SCLL) sclL <= regWdata[11:0];
      if (regWr && regAddr == imbs_pkg::OFS_HOLD) hold <= regWdata[11:0];
    end
  end
  AST_SCL_HELD: assert property (irq && !padOut.sclOeN |=> !padOut.sclOeN || !irq)
    else $error("scl released while interrupt pending");
  AST_IRQ_CLR: assert property (wSt && regWdata[7:0] == 8'h00 && irq |-> ##[1:2] !irq)
    else $error("pending flag kept after sources cleared");
  AST_FF_IDLE: assert property (wSt && regWdata[7:0] == 8'hFF |-> ##[1:2] padOut.sclOeN && padOut.sdaOeN && !irq)
    else $error("clear-all write did not idle");
  AST_DIS: assert property (wCt && !regWdata[7] |-> ##[1:2] padOut.sclOeN && padOut.sdaOeN)
    else $error("disabled unit still drives the bus");
  AST_IRQ_EN: assert property (wCt && !regWdata[4] |-> ##[1:2] !irq)
    else $error("request line high while disabled");
  AST_NO_START_IRQ: assert property ($fell(padOut.sdaOeN) && padOut.sclOeN |-> (!$rose(irq)) [*3])
    else $error("interrupt raised by start condition");
  AST_LOW: assert property ($rose(padOut.sclOeN) && !dirty |-> lowCnt == {2'h0, sclL, 2'h0} + 16'h3)
    else $error("scl low phase length wrong");
  AST_HOLD: assert property ($changed(padOut.sdaOeN) && !padOut.sclOeN && !dirty
    |-> lowCnt == {4'h0, hold} + 16'h2)
    else $error("sda hold after scl fall wrong");
  AST_RD_ZERO: assert property (regRdata != 32'h00000000 |-> $past(regRd))
    else $error("read data outside the answer cycle");
  cover property ($rose(irq));
  cover property (wSt && regWdata[7:0] == 8'hFF);
  cover property ($rose(padOut.sclOeN) && !dirty);
endmodule

bind imbs_top imbs_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinsIn(pinsIn),
  .padOut(padOut), .irq(irq));

// >>> dv/imbs_slave.sv
// behavioural slave: acks, returns one fixed byte, may stretch scl
`timescale 1ns/10ps
module imbs_slave (
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       stretch,
  input wire logic [7:0] txByte,
  output logic           sdaOeN,
  output logic           sclOeN,
  output logic [7:0]     rxByte
);
  int   bitCnt;  // bit index in byte
  logic act = 0; // between start and stop
  logic rd = 0;  // read transfer
  logic addr;    // address byte phase
  logic ackLast; // ack seen at ninth rise
  initial begin
    sdaOeN = 1'b1;
    sclOeN = 1'b1;
  end
  // start and stop while scl high
  always @(negedge sda) if (scl) begin
    act = 1;
    addr = 1;
    rd = 0;
    bitCnt = 0;
  end
  always @(posedge sda) if (scl) act = 0;
  // sample msb first on rise
  always @(posedge scl) if (act) begin
    if (bitCnt < 8) rxByte = {rxByte[6:0], sda};
    else ackLast = !sda;
    bitCnt++;
  end
  // drive on fall
  always @(negedge scl) if (act) begin
    if (bitCnt == 8) begin
      if (addr) rd = rxByte[0];
      sdaOeN = rd && !addr;
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      addr = 0;
      sdaOeN = (rd && ackLast) ? txByte[7] : 1'b1;
    end else if (rd && !addr && bitCnt > 0) sdaOeN = txByte[7-bitCnt];
    if (stretch && bitCnt == 4) begin
      sclOeN = 1'b0;
      #400 sclOeN = 1'b1;
    end
  end
endmodule

// >>> dv/imbs_top_test.sv
// self-checking bench for the i2c master byte sequencer
`timescale 1ns/10ps
module imbs_top_test;
  typedef struct packed {
    logic        wr;
    logic [4:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } imbs_row_t;
  logic                clk_sys = 1'b0;
  logic                resetn = 1'b0;
  logic [4:0]          regAddr = 5'h00;
  logic [31:0]         regWdata = 32'h0;
  logic                regWr = 1'b0;
  logic                regRd = 1'b0;
  logic [31:0]         regRdata;
  imbs_pkg::imbs_pad_t padOut;
  logic                irq;
  logic                slvSda;
  logic                slvScl;
  logic                tbSda = 1'b1;  // competing master pull
  logic                stretch = 1'b0;
  logic [7:0]          rxByte;
  logic [31:0]         rd;
  int                  fail_count = 0;
  int                  checked = 0;
  wire sclBus = padOut.sclOeN & slvScl;
  wire sdaBus = padOut.sdaOeN & slvSda & tbSda;
  imbs_row_t rows [13] = '{'{0, 5'h0C, 0, 32'h001}, '{0, 5'h10, 0, 32'h03F}, '{0, 5'h14, 0, 32'h03F},
    '{0, 5'h00, 0, 0}, '{0, 5'h04, 0, 0}, '{1, 5'h0C, 32'hABC, 32'hABC}, '{1, 5'h18, 32'hFF, 32'h7F},
    '{1, 5'h00, 32'h7E, 32'h16}, '{1, 5'h00, 0, 0}, '{1, 5'h1C, 32'hFF, 0}, '{1, 5'h10, 1, 1},
    '{1, 5'h14, 0, 0}, '{1, 5'h0C, 0, 0}};
  always #20 clk_sys = ~clk_sys;
  imbs_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pinsIn({sclBus, sdaBus}), .padOut(padOut), .irq(irq));
  imbs_slave u_slv (.scl(sclBus), .sda(sdaBus), .stretch(stretch), .txByte(8'h96), .sdaOeN(slvSda),
    .sclOeN(slvScl), .rxByte(rxByte));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdr(input logic [4:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  // wait for the interrupt line under a bound
  task automatic waitIrq;
    int n;
    n = 0;
    @(posedge clk_sys);
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 1000) begin
      fail_count++;
      print_verdict();
    end
  endtask
  // clear sources, then wait for the next event
  task automatic go(input logic [31:0] st);
    wr(imbs_pkg::OFS_STAT, st);
    waitIrq();
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rdr(rows[i].a);
      check(rd, rows[i].e);
    end
    $display("register table done");
    wr(imbs_pkg::OFS_DATA, 32'hA4);
    wr(imbs_pkg::OFS_CTRL, 32'h95);
    waitIrq();
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h43);
    wr(imbs_pkg::OFS_DATA, 32'h3C);
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h45);
    check(rxByte, 8'h3C);
    wr(imbs_pkg::OFS_DATA, 32'hA5);
    wr(imbs_pkg::OFS_CTRL, 32'h95);
    stretch <= 1'b1;
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h63);
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h65);
    rdr(imbs_pkg::OFS_DATA);
    check(rd, 32'h96);
    wr(imbs_pkg::OFS_CTRL, 32'h90);
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h64);
    wr(imbs_pkg::OFS_CTRL, 32'h96);
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd & 32'h1E, 32'h08);
    wr(imbs_pkg::OFS_STAT, 32'hFF);
    rdr(imbs_pkg::OFS_STAT);
    check(rd, 32'h00);
    $display("transfer sequence done");
    stretch <= 1'b0;
    wr(imbs_pkg::OFS_DATA, 32'hA4);
    wr(imbs_pkg::OFS_CTRL, 32'h95);
    waitIrq();
    wr(imbs_pkg::OFS_DATA, 32'hFF);
    tbSda <= 1'b0;
    go(0);
    rdr(imbs_pkg::OFS_STAT);
    check(rd & 32'h10, 32'h10);
    check(padOut.sclOeN, 1'b1);
    tbSda <= 1'b1;
    wr(imbs_pkg::OFS_STAT, 32'hFF);
    wr(imbs_pkg::OFS_CTRL, 32'h00);
    $display("arbitration loss done");
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdr(imbs_pkg::OFS_SCLL);
    check(rd, 32'h03F);
    $display("second reset done");
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    #4000000;
    fail_count++;
    print_verdict();
  end
endmodule

// >>> rtl/imbs_pkg.sv
// constants, field layouts and state types of the i2c master byte sequencer
// Overview of operation
// - interrupt on every bus event except START
// - pending flag set, auto-cleared when sources clear
// - SCL held low while any source set and master role held
// - bus-state register describes current bus condition
// - master/slave, transmitter/receiver modes, winner decides
// - unit enable bit gates the sequencer, but SCL stays low for a pending master
// - SCL phase lasts four times value plus three
// - hold register delays SDA after SCL fall
// - SDA changes hold value plus two clocks
// - start request sends START then address byte
// - slave acknowledge sampled in ninth high period
// - address-done interrupt, SCL held low afterwards
// - arbitration lost in address sets lost bit
// - slave handover needs ack enable, address match
// - arbitration checked during data, loss goes idle
// - transfer-end interrupt after each data byte, SCL low
// - stop request generates STOP regardless of ack
// - start request from wait sends repeated START
// - receiver acks next byte when enabled
// - received-ack flag records far side acknowledge
// - STOP raises stop flag, 0xFF write idles
package imbs_pkg;

  localparam int          REG_W        = 12;      // width of timing registers
  localparam int          TMR_W        = REG_W + 2; // width of phase counters
  localparam int          CLK_PERIOD_NS = 40;     // clk_sys period

  // register offsets
  localparam logic [4:0]  OFS_CTRL     = 5'h00;   // control_reg
  localparam logic [4:0]  OFS_STAT     = 5'h04;   // bus_state_reg
  localparam logic [4:0]  OFS_DATA     = 5'h08;   // shift_data_reg
  localparam logic [4:0]  OFS_HOLD     = 5'h0C;   // sda_hold_reg
  localparam logic [4:0]  OFS_SCLL     = 5'h10;   // scl_low_period_reg
  localparam logic [4:0]  OFS_SCLH     = 5'h14;   // scl_high_period_reg
  localparam logic [4:0]  OFS_OWN      = 5'h18;   // own_address_regs

  // control_reg bit positions
  localparam int          CT_START     = 0;       // start_request_bit
  localparam int          CT_STOP      = 1;       // stop_request_bit
  localparam int          CT_ACKEN     = 2;       // ack_enable_bit
  localparam int          CT_PEND      = 3;       // irq_pending_flag, read only
  localparam int          CT_IRQEN     = 4;       // interrupt enable
  localparam int          CT_EN        = 7;       // unit_enable_bit
  localparam logic [7:0]  CT_WMASK     = 8'h97;   // writable control bits

  // bus_state_reg bit positions
  localparam int          ST_RXACK     = 0;       // received_ack_flag
  localparam int          ST_ADDR      = 1;       // address_done_irq source
  localparam int          ST_XFER      = 2;       // transfer_end_irq source
  localparam int          ST_STOP      = 3;       // stop source
  localparam int          ST_LOST      = 4;       // arbitration_lost_bit source
  localparam int          ST_RX        = 5;       // receiver direction
  localparam int          ST_MASTER    = 6;       // master role held
  localparam int          ST_SLAVE     = 7;       // handed over to slave
  localparam logic [7:0]  ST_SRC_MASK  = 8'h1E;   // interrupt source bits
  localparam logic [7:0]  ST_CLR_ALL   = 8'hFF;   // clear-all write value

  // reset values
  localparam logic [REG_W-1:0] HOLD_RST = 12'h001;
  localparam logic [REG_W-1:0] SCL_RST  = 12'h03F;

  // phase timing: 4 * value + 3, sda hold: value + 2
  localparam logic [1:0]  PHASE_LSB    = 2'h2;    // low bits of 4*v+3-1
  localparam logic [TMR_W-1:0] HOLD_ADD = 14'h0001; // hold + 2 - 1
  localparam logic [3:0]  ACK_BIT      = 4'h8;    // index of ninth bit

  // sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_START, S_LOW, S_HIGH, S_WAIT,
    S_RSTART, S_STOP_LOW, S_STOP_HIGH, S_LOST
  } imbs_fsm_t;

  // sampled bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } imbs_pins_t;

  // open-drain pad drive
  typedef struct packed {
    logic sclOut;
    logic sclOeN;
    logic sdaOut;
    logic sdaOeN;
  } imbs_pad_t;

  // complete state of the sequencer
  typedef struct packed {
    imbs_fsm_t        fsm;
    logic [7:0]       ctrl;
    logic [7:0]       stat;
    logic [7:0]       shift;
    logic [REG_W-1:0] hold;
    logic [REG_W-1:0] sclL;
    logic [REG_W-1:0] sclH;
    logic [6:0]       own;
    logic [3:0]       bitCnt;
    logic             addrPhase;
    logic             hiRun;
    logic             sdaSet;
    logic             sclPrev;
    imbs_pad_t        pad;
    logic             irq;
    logic [31:0]      rdata;
  } imbs_state_t;

endpackage

// >>> rtl/imbs_sync.sv
// two-flop synchroniser for the sampled bus lines
`timescale 1ns/10ps
module imbs_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // both stages in one state word
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } imbs_sync_t;

  imbs_sync_t cur_reg;   // registered stages
  imbs_sync_t cur_next;  // next stages

  if (W < 1) begin : g_chk
    $error("imbs_sync width must be positive");
  end

  // first stage is read only by the second
  always_comb begin
    cur_next        = cur_reg;
    cur_next.meta   = din;
    cur_next.stable = cur_reg.meta;
  end

  // idle bus level is high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '1;
    end else if (ce) begin
      cur_reg <= cur_next;
    end
  end

  assign dout = cur_reg.stable;

endmodule

// >>> rtl/imbs_timer.sv
// loadable down counter for phase and hold timing
`timescale 1ns/10ps
module imbs_timer #(
  parameter int W = 14
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] loadVal,
  output logic              done
);

  // counter state
  typedef struct packed {
    logic [W-1:0] cnt;
  } imbs_tmr_t;

  imbs_tmr_t cur_reg;   // registered count
  imbs_tmr_t cur_next;  // next count

  if (W < 2) begin : g_chk
    $error("imbs_timer width too small");
  end

  // load wins, otherwise count down to zero and stay
  always_comb begin
    cur_next = cur_reg;
    if (load) begin
      cur_next.cnt = loadVal;
    end else if (cur_reg.cnt != '0) begin
      cur_next.cnt = cur_reg.cnt - 1'b1;
    end
  end

  // count register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '0;
    end else if (ce) begin
      cur_reg <= cur_next;
    end
  end

  assign done = (cur_reg.cnt == '0);

endmodule

// >>> rtl/imbs_top.sv
// i2c master byte sequencer with register port and open-drain pads
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module imbs_top (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 ce,
  input  wire logic [4:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdata,
  input  wire imbs_pkg::imbs_pins_t pinsIn,
  output imbs_pkg::imbs_pad_t       padOut,
  output logic                      irq
);

  imbs_pkg::imbs_state_t      cur_reg;   // registered state
  imbs_pkg::imbs_state_t      cur_next;  // next state
  imbs_pkg::imbs_pins_t       pinsS;     // synchronised bus lines
  logic                       phDone;    // phase timer expired
  logic                       hdDone;    // hold timer expired
  logic                       loadPh;    // restart phase timer
  logic                       loadHd;    // restart hold timer
  logic [imbs_pkg::TMR_W-1:0] valPh;     // phase timer value
  logic [imbs_pkg::TMR_W-1:0] valHd;     // hold timer value

  // bus lines come from another domain
  imbs_sync #(
    .W       (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .din     (pinsIn),
    .dout    (pinsS)
  );

  // scl low and high phase timer
  imbs_timer #(
    .W       (imbs_pkg::TMR_W)
  ) u_phase (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .load    (loadPh),
    .loadVal (valPh),
    .done    (phDone)
  );

  // sda hold delay after scl fall
  imbs_timer #(
    .W       (imbs_pkg::TMR_W)
  ) u_hold (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .load    (loadHd),
    .loadVal (valHd),
    .done    (hdDone)
  );

  // sequencer, register file and pad control
  always_comb begin
    logic       rxByte;   // data byte read from slave
    logic       txBit;    // level this end puts on sda
    logic [7:0] sampled;  // shift with the new bus bit
    cur_next = cur_reg;
    loadPh   = 1'b0;
    loadHd   = 1'b0;
    valPh    = {cur_reg.sclL, imbs_pkg::PHASE_LSB};
    valHd    = {2'h0, cur_reg.hold} + imbs_pkg::HOLD_ADD;
    rxByte   = !cur_reg.addrPhase && cur_reg.stat[imbs_pkg::ST_RX];
    sampled  = {cur_reg.shift[6:0], pinsS.sda};
    // data bits msb first, ninth bit is the acknowledge
    if (cur_reg.bitCnt < imbs_pkg::ACK_BIT) begin
      txBit = rxByte ? 1'b1 : cur_reg.shift[7];
    end else begin
      txBit = rxByte ? !cur_reg.ctrl[imbs_pkg::CT_ACKEN] : 1'b1;
    end
    cur_next.sclPrev = pinsS.scl;

    // software writes, hardware sets below win
    if (regWr) begin
      unique case (regAddr)
        imbs_pkg::OFS_CTRL: begin
          cur_next.ctrl = (regWdata[7:0] & imbs_pkg::CT_WMASK)
                        | (cur_reg.ctrl & ~imbs_pkg::CT_WMASK);
        end
        imbs_pkg::OFS_STAT: begin
          if (regWdata[7:0] == imbs_pkg::ST_CLR_ALL) begin
            // clear all and return to idle
            cur_next.stat          = '0;
            cur_next.fsm           = imbs_pkg::S_IDLE;
            cur_next.pad.sclOeN    = 1'b1;
            cur_next.pad.sdaOeN    = 1'b1;
          end else begin
            // zero written clears a source bit
            cur_next.stat = cur_reg.stat & (regWdata[7:0] | ~imbs_pkg::ST_SRC_MASK);
          end
        end
        imbs_pkg::OFS_DATA: begin
          cur_next.shift = regWdata[7:0];
        end
        imbs_pkg::OFS_HOLD: begin
          cur_next.hold = regWdata[imbs_pkg::REG_W-1:0];
        end
        imbs_pkg::OFS_SCLL: begin
          cur_next.sclL = regWdata[imbs_pkg::REG_W-1:0];
        end
        imbs_pkg::OFS_SCLH: begin
          cur_next.sclH = regWdata[imbs_pkg::REG_W-1:0];
        end
        imbs_pkg::OFS_OWN: begin
          cur_next.own = regWdata[6:0];
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end

    // bus sequencer
    unique case (cur_reg.fsm)
      imbs_pkg::S_IDLE: begin
        cur_next.pad.sclOeN = 1'b1;
        cur_next.pad.sdaOeN = 1'b1;
        // start only on a free bus, no interrupt for START
        if (cur_reg.ctrl[imbs_pkg::CT_START] && pinsS.scl && pinsS.sda) begin
          cur_next.fsm                    = imbs_pkg::S_START;
          cur_next.pad.sdaOeN             = 1'b0;
          cur_next.stat[imbs_pkg::ST_MASTER] = 1'b1;
          cur_next.stat[imbs_pkg::ST_SLAVE]  = 1'b0;
          loadPh = 1'b1;
          valPh  = {cur_reg.sclH, imbs_pkg::PHASE_LSB};
        end
      end
      imbs_pkg::S_START: begin
        // sda low while scl high, then first low phase
        if (phDone) begin
          cur_next.fsm                    = imbs_pkg::S_LOW;
          cur_next.ctrl[imbs_pkg::CT_START] = 1'b0;
          cur_next.pad.sclOeN             = 1'b0;
          cur_next.bitCnt                 = '0;
          cur_next.addrPhase              = 1'b1;
          cur_next.sdaSet                 = 1'b0;
          loadPh = 1'b1;
          loadHd = 1'b1;
        end
      end
      imbs_pkg::S_LOW: begin
        // sda moves once the hold delay has run out
        if (hdDone && !cur_reg.sdaSet) begin
          cur_next.pad.sdaOeN = txBit;
          cur_next.sdaSet     = 1'b1;
        end
        // low phase of 4*low+3 clocks
        if (phDone && cur_reg.sdaSet) begin
          cur_next.fsm        = imbs_pkg::S_HIGH;
          cur_next.pad.sclOeN = 1'b1;
          cur_next.hiRun      = 1'b0;
        end
      end
      imbs_pkg::S_HIGH: begin
        if (!cur_reg.hiRun) begin
          // wait for a stretching slave, then time the high phase
          if (pinsS.scl) begin
            cur_next.hiRun = 1'b1;
            loadPh = 1'b1;
            valPh  = {cur_reg.sclH, imbs_pkg::PHASE_LSB};
            if (cur_reg.bitCnt < imbs_pkg::ACK_BIT) begin
              cur_next.shift = sampled;
              // released high but bus low: another master won
              if (txBit && !pinsS.sda && !rxByte) begin
                cur_next.stat[imbs_pkg::ST_LOST]   = 1'b1;
                cur_next.stat[imbs_pkg::ST_MASTER] = 1'b0;
                cur_next.pad.sdaOeN = 1'b1;
                cur_next.bitCnt     = cur_reg.bitCnt + 4'h1;
                cur_next.fsm = cur_reg.addrPhase ? imbs_pkg::S_LOST : imbs_pkg::S_IDLE;
              end
            end else begin
              cur_next.stat[imbs_pkg::ST_RXACK] = !pinsS.sda;
            end
          end
        end else if (phDone) begin
          cur_next.pad.sclOeN = 1'b0;
          cur_next.sdaSet     = 1'b0;
          if (cur_reg.bitCnt == imbs_pkg::ACK_BIT) begin
            // byte complete, hold scl low for software
            cur_next.fsm = imbs_pkg::S_WAIT;
            if (cur_reg.addrPhase) begin
              cur_next.stat[imbs_pkg::ST_ADDR] = 1'b1;
              cur_next.stat[imbs_pkg::ST_RX]   = cur_reg.shift[0];
              cur_next.addrPhase = 1'b0;
            end else begin
              cur_next.stat[imbs_pkg::ST_XFER] = 1'b1;
            end
          end else begin
            cur_next.fsm    = imbs_pkg::S_LOW;
            cur_next.bitCnt = cur_reg.bitCnt + 4'h1;
            loadPh = 1'b1;
            loadHd = 1'b1;
          end
        end
      end
      imbs_pkg::S_WAIT: begin
        // scl stays low until every source is cleared
        cur_next.pad.sclOeN = 1'b0;
        if ((cur_reg.stat & imbs_pkg::ST_SRC_MASK) == '0) begin
          loadPh = 1'b1;
          cur_next.hiRun  = 1'b0; // re-arm for a repeated start
          loadHd = 1'b1;
          cur_next.sdaSet = 1'b0;
          if (cur_reg.ctrl[imbs_pkg::CT_STOP]) begin
            cur_next.fsm = imbs_pkg::S_STOP_LOW;
          end else if (cur_reg.ctrl[imbs_pkg::CT_START]) begin
            cur_next.fsm = imbs_pkg::S_RSTART;
          end else begin
            cur_next.fsm    = imbs_pkg::S_LOW;
            cur_next.bitCnt = '0;
          end
        end
      end
      imbs_pkg::S_RSTART: begin
        // release sda in the low phase, raise scl, then START
        if (!cur_reg.sdaSet) begin
          if (hdDone) begin
            cur_next.pad.sdaOeN = 1'b1;
            cur_next.sdaSet     = 1'b1;
          end
        end else if (!cur_reg.hiRun) begin
          if (phDone) begin
            cur_next.pad.sclOeN = 1'b1;
            cur_next.hiRun      = 1'b1;
          end
        end else if (pinsS.scl) begin
          cur_next.fsm        = imbs_pkg::S_START;
          cur_next.pad.sdaOeN = 1'b0;
          cur_next.hiRun      = 1'b0;
          loadPh = 1'b1;
          valPh  = {cur_reg.sclH, imbs_pkg::PHASE_LSB};
        end
      end
      imbs_pkg::S_STOP_LOW: begin
        // pull sda low under low scl, then raise scl
        if (hdDone && !cur_reg.sdaSet) begin
          cur_next.pad.sdaOeN = 1'b0;
          cur_next.sdaSet     = 1'b1;
        end
        if (phDone && cur_reg.sdaSet) begin
          cur_next.fsm        = imbs_pkg::S_STOP_HIGH;
          cur_next.pad.sclOeN = 1'b1;
          cur_next.hiRun      = 1'b0;
        end
      end
      imbs_pkg::S_STOP_HIGH: begin
        if (!cur_reg.hiRun) begin
          if (pinsS.scl) begin
            cur_next.hiRun = 1'b1;
            loadPh = 1'b1;
            valPh  = {cur_reg.sclH, imbs_pkg::PHASE_LSB};
          end
        end else if (phDone) begin
          // sda rises while scl high
          cur_next.pad.sdaOeN               = 1'b1;
          cur_next.stat[imbs_pkg::ST_STOP]   = 1'b1;
          cur_next.stat[imbs_pkg::ST_MASTER] = 1'b0;
          cur_next.ctrl[imbs_pkg::CT_STOP]   = 1'b0;
          cur_next.fsm                      = imbs_pkg::S_IDLE;
        end
      end
      imbs_pkg::S_LOST: begin
        // follow the winner's address bits passively
        cur_next.pad.sclOeN = 1'b1;
        cur_next.pad.sdaOeN = 1'b1;
        if (pinsS.scl && !cur_reg.sclPrev) begin
          cur_next.shift  = sampled;
          cur_next.bitCnt = cur_reg.bitCnt + 4'h1;
          if (cur_reg.bitCnt == 4'h7) begin
            cur_next.fsm = imbs_pkg::S_IDLE;
            if (cur_reg.ctrl[imbs_pkg::CT_ACKEN] && sampled[7:1] == cur_reg.own) begin
              cur_next.stat[imbs_pkg::ST_SLAVE] = 1'b1;
              cur_next.stat[imbs_pkg::ST_RX]    = sampled[0];
            end
          end
        end
      end
      default: begin
        cur_next.fsm = imbs_pkg::S_IDLE;
      end
    endcase

    // disabled unit goes idle and releases the bus, except scl stays low for a pending master
    if (!cur_reg.ctrl[imbs_pkg::CT_EN]) begin
      cur_next.fsm        = imbs_pkg::S_IDLE;
      cur_next.pad.sclOeN = 1'b1;
      cur_next.pad.sdaOeN = 1'b1;
    end

    // pending flag follows the source bits
    cur_next.ctrl[imbs_pkg::CT_PEND] = |(cur_next.stat & imbs_pkg::ST_SRC_MASK);
    // pending master holds the clock low
    if (cur_next.ctrl[imbs_pkg::CT_PEND] && cur_next.stat[imbs_pkg::ST_MASTER]) begin
      cur_next.pad.sclOeN = 1'b0;
    end
    cur_next.irq = cur_next.ctrl[imbs_pkg::CT_PEND] && cur_next.ctrl[imbs_pkg::CT_IRQEN];

    // read data valid only in the cycle after the strobe
    cur_next.rdata = '0;
    if (regRd) begin
      unique case (regAddr)
        imbs_pkg::OFS_CTRL: cur_next.rdata = {24'h0, cur_reg.ctrl};
        imbs_pkg::OFS_STAT: cur_next.rdata = {24'h0, cur_reg.stat};
        imbs_pkg::OFS_DATA: cur_next.rdata = {24'h0, cur_reg.shift};
        imbs_pkg::OFS_HOLD: cur_next.rdata = {20'h0, cur_reg.hold};
        imbs_pkg::OFS_SCLL: cur_next.rdata = {20'h0, cur_reg.sclL};
        imbs_pkg::OFS_SCLH: cur_next.rdata = {20'h0, cur_reg.sclH};
        imbs_pkg::OFS_OWN:  cur_next.rdata = {25'h0, cur_reg.own};
        default:            cur_next.rdata = '0;
      endcase
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cur_reg            <= '0;
      cur_reg.fsm        <= imbs_pkg::S_IDLE;
      cur_reg.hold       <= imbs_pkg::HOLD_RST;
      cur_reg.sclL       <= imbs_pkg::SCL_RST;
      cur_reg.sclH       <= imbs_pkg::SCL_RST;
      cur_reg.sclPrev    <= 1'b1;
      cur_reg.pad.sclOeN <= 1'b1;
      cur_reg.pad.sdaOeN <= 1'b1;
    end else if (ce) begin
      cur_reg <= cur_next;
    end
  end

  // outputs straight from the state register
  assign regRdata = cur_reg.rdata;
  assign padOut   = cur_reg.pad;
  assign irq      = cur_reg.irq;

endmodule
